// File: design/pwm_channel.sv
/*
 * one 8-bit pwm channel: clock gate synchroniser, period counter and
 * output flip-flop with polarity select.
 * assumes: tick_in is a one-cycle pulse on sys_clk_in marking one edge
 * of the selected channel clock; settings come from same-clock flops.
 */
`timescale 1ns/1ps
module pwm_channel (
  input  wire logic                       sys_clk_in,
  input  wire logic                       sys_rst_in,
  input  wire logic                       clk_en_in,
  input  wire logic                       tick_in,
  input  wire logic                       enable_in,
  input  wire logic                       start_high_in,
  input  wire logic [pwm_pkg::REG_W-1:0]  duty_in,
  input  wire logic [pwm_pkg::REG_W-1:0]  period_in,
  output logic                            run_out,
  output logic                            wave_out
);
  import pwm_pkg::*;

  logic [REG_W-1:0] cnt_q;
  logic [REG_W-1:0] period_m1;
  logic             in_duty;

  // period of zero wraps to 256 counts
  assign period_m1 = period_in - CNT_ONE;
  assign in_duty   = (cnt_q < duty_in);

  // gate at edge
  // enable only switches on a channel clock edge, so no pulse is cut
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      run_out <= 1'b0;
    end else if (clk_en_in && tick_in) begin
      run_out <= enable_in;
    end
  end

  // period counter
  // counter restarts from zero whenever the channel is (re)started
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      cnt_q <= CNT_ZERO;
    end else if (clk_en_in && tick_in) begin
      if (!run_out || cnt_q == period_m1) begin
        cnt_q <= CNT_ZERO;
      end else begin
        cnt_q <= cnt_q + CNT_ONE;
      end
    end
  end

  // polarity select
  // start level until duty count, then the other level
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      wave_out <= 1'b0;
    end else if (clk_en_in) begin
      wave_out <= run_out && (start_high_in ? in_duty : !in_duty);
    end
  end

  // ********************************************************************
  // checks
  // ********************************************************************
  a_count_wrap: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (clk_en_in && tick_in && run_out && cnt_q == period_m1)
      |=> (cnt_q == CNT_ZERO))
    else $error("channel counter did not restart at period end");

  a_enable_edge: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    $changed(run_out) |-> $past(tick_in) && $past(clk_en_in))
    else $error("channel gate changed away from a clock edge");

  a_start_level: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (clk_en_in && run_out && cnt_q == CNT_ZERO && duty_in != CNT_ZERO)
      |=> (wave_out == $past(start_high_in)))
    else $error("cycle did not begin at the selected start level");

endmodule

// File: design/pwm_ctrl.sv
/*
 * apb register file and clock generation of a four-channel 8-bit pwm
 * timer: prescaled clocks, scaled clock divider, per-channel clock
 * select, polarity, enable and port direction override.
 * assumes: apb master on sys_clk_in (the bus clock), test_mode_in from a
 * pin, port_dir_in from the same-clock port direction register.
 */
`timescale 1ns/1ps
module pwm_ctrl (
  input  wire logic                         sys_clk_in,
  input  wire logic                         sys_rst_in,
  input  wire logic                         clk_en_in,
  input  wire logic                         psel_in,
  input  wire logic                         penable_in,
  input  wire logic                         pwrite_in,
  input  wire logic [pwm_pkg::ADDR_W-1:0]   paddr_in,
  input  wire logic [pwm_pkg::DATA_W-1:0]   pwdata_in,
  output logic      [pwm_pkg::DATA_W-1:0]   prdata_out,
  output logic                              pready_out,
  output logic                              pslverr_out,
  input  wire logic                         test_mode_in,
  input  wire logic [pwm_pkg::NUM_CH-1:0]   port_dir_in,
  output logic      [pwm_pkg::NUM_CH-1:0]   port_oe_out,
  output logic      [pwm_pkg::NUM_CH-1:0]   pwm_out
);
  import pwm_pkg::*;

  // ********************************************************************
  // registers and internal signals
  // ********************************************************************
  logic [REG_W-1:0]  selpol_q;
  logic [REG_W-1:0]  enable_q;
  logic [REG_W-1:0]  scale_q;
  logic [REG_W-1:0]  test_q;
  logic [REG_W-1:0]  prescl_q;
  logic [REG_W-1:0]  duty_q   [NUM_CH];
  logic [REG_W-1:0]  period_q [NUM_CH];

  logic [PRE_W-1:0]  pre_cnt_q;
  logic [REG_W-1:0]  scale_cnt_q;
  logic              clk_s_q;
  logic              test_sync1_q;
  logic              test_sync2_q;

  logic [PRE_W-1:0]  mask_a;
  logic [PRE_W-1:0]  mask_b;
  logic              tick_a;
  logic              tick_b;
  logic              tick_s;
  logic              s_wrap;
  logic [REG_W-1:0]  scale_m1;

  logic [NUM_CH-1:0] ch_tick;
  logic [NUM_CH-1:0] ch_run;
  logic [NUM_CH-1:0] ch_wave;

  logic              access;
  logic              do_write;
  logic [IDX_W-1:0]  idx;
  logic              idx_ok;
  logic              wr_scale;
  logic [REG_W-1:0]  rd_byte;
  logic              duty_hit;
  logic              period_hit;
  logic [1:0]        sub_idx;

  // ********************************************************************
  // apb decode
  // ********************************************************************

  // one wait state: pready rises in the second access cycle
  assign access   = psel_in && penable_in;
  assign do_write = access && pready_out && pwrite_in;
  assign idx      = paddr_in[ADDR_W-1:2];
  assign sub_idx  = idx[1:0];

  // duty and period registers sit in blocks of four indices
  assign duty_hit   = (idx[IDX_W-1:2] == IDX_DUTY0[IDX_W-1:2]);
  assign period_hit = (idx[IDX_W-1:2] == IDX_PERIOD0[IDX_W-1:2]);

  // index map and read multiplexer
  always_comb begin
    idx_ok  = 1'b1;
    rd_byte = RST_REG;
    if (paddr_in[1:0] != 2'h0) begin
      idx_ok = 1'b0;
    end else if (idx == IDX_SELPOL) begin
      rd_byte = selpol_q;
    end else if (idx == IDX_ENABLE) begin
      rd_byte = enable_q;
    end else if (idx == IDX_SCALE) begin
      // test readback
      // test path shows the live scaling counter, not the divisor
      if (test_sync2_q && test_q[TREAD_BIT]) begin
        rd_byte = scale_cnt_q;
      end else begin
        rd_byte = scale_q;
      end
    end else if (idx == IDX_TEST) begin
      rd_byte = test_q;
    end else if (duty_hit) begin
      rd_byte = duty_q[sub_idx];
    end else if (period_hit) begin
      rd_byte = period_q[sub_idx];
    end else if (idx == IDX_PRESCL) begin
      rd_byte = prescl_q;
    end else begin
      idx_ok = 1'b0;
    end
  end

  assign wr_scale = do_write && idx_ok && (idx == IDX_SCALE);

  // answer: pready, read data and error all change together
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= '0;
    end else if (clk_en_in) begin
      pready_out  <= access && !pready_out;
      pslverr_out <= access && !pready_out && !idx_ok;
      if (access && !pready_out && !pwrite_in) begin
        prdata_out <= {{(DATA_W-REG_W){1'b0}}, rd_byte};
      end
    end
  end

  // ********************************************************************
  // software registers
  // ********************************************************************

  // control registers, written only at the completing edge
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      selpol_q <= RST_REG;
      enable_q <= RST_REG;
      scale_q  <= RST_REG;
      test_q   <= RST_REG;
      prescl_q <= RST_REG;
    end else if (clk_en_in && do_write && idx_ok) begin
      if (idx == IDX_SELPOL) begin
        selpol_q <= pwdata_in[REG_W-1:0];
      end else if (idx == IDX_ENABLE) begin
        enable_q <= pwdata_in[REG_W-1:0];
      end else if (idx == IDX_SCALE) begin
        scale_q <= pwdata_in[REG_W-1:0];
      end else if (idx == IDX_TEST) begin
        test_q <= pwdata_in[REG_W-1:0];
      end else if (idx == IDX_PRESCL) begin
        prescl_q <= pwdata_in[REG_W-1:0];
      end
    end
  end

  // duty and period per channel
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < NUM_CH; i++) begin
        duty_q[i]   <= RST_REG;
        period_q[i] <= RST_PERIOD;
      end
    end else if (clk_en_in && do_write && idx_ok) begin
      if (duty_hit) begin
        duty_q[sub_idx] <= pwdata_in[REG_W-1:0];
      end else if (period_hit) begin
        period_q[sub_idx] <= pwdata_in[REG_W-1:0];
      end
    end
  end

  // test pin comes from outside: two flops before use
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      test_sync1_q <= 1'b0;
      test_sync2_q <= 1'b0;
    end else if (clk_en_in) begin
      test_sync1_q <= test_mode_in;
      test_sync2_q <= test_sync1_q;
    end
  end

  // ********************************************************************
  // prescaled clocks
  // ********************************************************************

  // free-running prescaler; ticks mark the last bus cycle of each period
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      pre_cnt_q <= '0;
    end else if (clk_en_in) begin
      pre_cnt_q <= pre_cnt_q + PRE_W'(1);
    end
  end

  assign mask_a = PRE_W'((8'h01 << prescl_q[PREA_LSB +: 2]) - 8'h01);
  assign tick_a = ((pre_cnt_q & mask_a) == mask_a);

  assign mask_b = PRE_W'((8'h01 << prescl_q[PREB_LSB +: 3]) - 8'h01);
  assign tick_b = ((pre_cnt_q & mask_b) == mask_b);

  // ********************************************************************
  // scaled clock
  // ********************************************************************

  // divisor of zero wraps to 255 here, giving the 256 count
  assign scale_m1 = scale_q - CNT_ONE;
  assign s_wrap   = tick_a && (scale_cnt_q == scale_m1);
  assign tick_s   = s_wrap && !clk_s_q;

  // write clears counter
  // a write wins over counting so the new divisor starts clean
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      scale_cnt_q <= CNT_ZERO;
    end else if (clk_en_in) begin
      if (wr_scale) begin
        scale_cnt_q <= CNT_ZERO;
      end else if (s_wrap) begin
        scale_cnt_q <= CNT_ZERO;
      end else if (tick_a) begin
        scale_cnt_q <= scale_cnt_q + CNT_ONE;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      clk_s_q <= 1'b0;
    end else if (clk_en_in && s_wrap && !wr_scale) begin
      clk_s_q <= !clk_s_q;
    end
  end

  // ********************************************************************
  // channels
  // ********************************************************************
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      // pair select: low pair on prescaler a, high pair on prescaler b
      // select may switch at any time; a cut pulse is accepted
      if (g < 2) begin : g_a
        assign ch_tick[g] = selpol_q[CSEL_LSB+g] ? tick_s : tick_a;
      end else begin : g_b
        assign ch_tick[g] = selpol_q[CSEL_LSB+g] ? tick_s : tick_b;
      end

      pwm_channel u_ch (
        .sys_clk_in    (sys_clk_in),
        .sys_rst_in    (sys_rst_in),
        .clk_en_in     (clk_en_in),
        .tick_in       (ch_tick[g]),
        .enable_in     (enable_q[g]),
        .start_high_in (selpol_q[POL_LSB+g]),
        .duty_in       (duty_q[g]),
        .period_in     (period_q[g]),
        .run_out       (ch_run[g]),
        .wave_out      (ch_wave[g])
      );
    end
  endgenerate

  // ********************************************************************
  // port pins
  // ********************************************************************

  // enable forces output
  // direction input is never written, so it rules again once disabled
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      port_oe_out <= '0;
    end else if (clk_en_in) begin
      port_oe_out <= enable_q[NUM_CH-1:0] | port_dir_in;
    end
  end

  // channel to port bit
  // channel n drives port bit n once its gate has opened
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      pwm_out <= '0;
    end else if (clk_en_in) begin
      pwm_out <= ch_wave & ch_run;
    end
  end

  // ********************************************************************
  // checks
  // ********************************************************************
  sequence s_apb_first;
    psel_in && penable_in && !pready_out && clk_en_in;
  endsequence

  sequence s_apb_done;
    pready_out ##1 !pready_out;
  endsequence

  a_apb_one_wait: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    s_apb_first |=> s_apb_done)
    else $error("apb answer not given after one wait state");

  a_scale_clear: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (clk_en_in && wr_scale) |=> (scale_cnt_q == CNT_ZERO))
    else $error("divisor write did not clear the scaling counter");

  a_oe_forced: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (clk_en_in && enable_q[0] && !port_dir_in[0]) |=> port_oe_out[0])
    else $error("enabled channel did not force its port line");

  a_test_read: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (clk_en_in && psel_in && penable_in && !pready_out && !pwrite_in
     && idx == IDX_SCALE && test_sync2_q && test_q[TREAD_BIT])
      |=> (prdata_out[REG_W-1:0] == $past(scale_cnt_q)))
    else $error("test readback did not return the scaling counter");

  a_s_halving: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    (clk_en_in && s_wrap && !wr_scale) |=> (clk_s_q != $past(clk_s_q)))
    else $error("scaled clock did not toggle at divider wrap");

endmodule

// File: design/pwm_pkg.sv
/*
 * shared constants of the four-channel pwm control block: register
 * indices, field positions, reset values and widths.
 * assumes: the apb slave turns an index into a byte address as index*4.
 */
package pwm_pkg;

  // ********************************************************************
  // widths
  // ********************************************************************
  localparam int unsigned ADDR_W   = 16;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned REG_W    = 8;
  localparam int unsigned IDX_W    = 14;
  localparam int unsigned NUM_CH   = 4;
  localparam int unsigned PRE_W    = 7;

  // ********************************************************************
  // register indices (byte address is index times four)
  // ********************************************************************
  localparam logic [IDX_W-1:0] IDX_SELPOL  = 14'h1060;
  localparam logic [IDX_W-1:0] IDX_ENABLE  = 14'h1061;
  localparam logic [IDX_W-1:0] IDX_SCALE   = 14'h1062;
  localparam logic [IDX_W-1:0] IDX_TEST    = 14'h1063;
  localparam logic [IDX_W-1:0] IDX_DUTY0   = 14'h1064;
  localparam logic [IDX_W-1:0] IDX_PERIOD0 = 14'h1068;
  localparam logic [IDX_W-1:0] IDX_PRESCL  = 14'h106c;

  // ********************************************************************
  // field positions
  // ********************************************************************
  localparam int unsigned POL_LSB   = 0;  // start_high_select[3:0]
  localparam int unsigned CSEL_LSB  = 4;  // channel_scaled_clock_select
  localparam int unsigned PREA_LSB  = 0;  // first_prescale_field, 2 bits
  localparam int unsigned PREB_LSB  = 4;  // second_prescale_field, 3 bits
  localparam int unsigned TREAD_BIT = 0;  // test_scaled_clock_readback

  // ********************************************************************
  // reset values
  // ********************************************************************
  localparam logic [REG_W-1:0] RST_REG    = 8'h00;
  localparam logic [REG_W-1:0] RST_PERIOD = 8'hff;
  localparam logic [REG_W-1:0] CNT_ZERO   = 8'h00;
  localparam logic [REG_W-1:0] CNT_ONE    = 8'h01;

endpackage

// File: verif/pin_load.sv
/*
 * external loads on the four port lines fed by the pwm block.
 * assumes: one bus clock; a line nobody drives floats with no pull.
 */
`timescale 1ns/1ps
module pin_load (
  input  wire logic       sys_clk_in,
  input  wire logic [3:0] oe_in,
  input  wire logic [3:0] drive_in,
  output logic      [3:0] pin_out
);
  // ******************************************************************
  // line level
  // ******************************************************************
  logic [3:0] last_q = 4'h0;

  // a floating line shows the inverse of its last level, so a stale
  // value is never taken for a driven one
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_out[i] = oe_in[i] ? drive_in[i] : ~last_q[i];
    end
  end

  // level last seen by each load
  always @(posedge sys_clk_in) begin
    last_q <= pin_out;
  end
endmodule

// File: verif/testbench.sv
/*
 * self-checking bench of the pwm control block: register access,
 * reset values, refused addresses, test readback, port override and
 * measured waveforms for every prescale code and the scaled clock.
 * assumes: pin_load models the port loads; bus clock is 10 MHz.
 */
`timescale 1ns/1ps
module testbench;
  import pwm_pkg::*;
  // ******************************************************************
  // signals
  // ******************************************************************
  logic              sys_clk;
  logic              sys_rst;
  logic              clk_en;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              test_mode;
  logic [NUM_CH-1:0] port_dir;
  logic [NUM_CH-1:0] port_oe;
  logic [NUM_CH-1:0] pwm;
  logic [NUM_CH-1:0] pin;
  logic [33:0]       exp_q[$];
  logic [33:0]       e_v;
  logic [DATA_W-1:0] rd;
  int                n_mismatch = 0;
  int                n_checks = 0;
  int                seed;
  int                d;

  pwm_ctrl DUT (
    .sys_clk_in   (sys_clk),
    .sys_rst_in   (sys_rst),
    .clk_en_in    (clk_en),
    .psel_in      (psel),
    .penable_in   (penable),
    .pwrite_in    (pwrite),
    .paddr_in     (paddr),
    .pwdata_in    (pwdata),
    .prdata_out   (prdata),
    .pready_out   (pready),
    .pslverr_out  (pslverr),
    .test_mode_in (test_mode),
    .port_dir_in  (port_dir),
    .port_oe_out  (port_oe),
    .pwm_out      (pwm)
  );

  pin_load load (
    .sys_clk_in (sys_clk),
    .oe_in      (port_oe),
    .drive_in   (pwm),
    .pin_out    (pin)
  );

  // ******************************************************************
  // clock, checks and bus tasks
  // ******************************************************************
  // 100 ns period
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // note layout: {is read, expected error, expected data}
  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [31:0] dat, input logic [33:0] e);
    exp_q.push_back(e);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge sys_clk);
    penable <= 1'b1;
    // no assumed latency: only the watchdog ends this wait
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [13:0] idx, input logic [7:0] v);
    apb(1'b1, {idx, 2'b00}, {24'h0, v}, 34'h0);
  endtask

  task automatic rdc(input logic [13:0] idx, input logic [7:0] v);
    apb(1'b0, {idx, 2'b00}, 32'h0, {2'b10, 24'h0, v});
  endtask

  // compares each answer with the oldest note
  always @(posedge sys_clk) begin
    if (pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(32'h0, 32'h1);
      end else begin
        e_v = exp_q.pop_front();
        chk({31'h0, pslverr}, {31'h0, e_v[32]});
        if (e_v[33]) chk(prdata, e_v[31:0]);
      end
    end
  end

  // ******************************************************************
  // waveform measurement
  // ******************************************************************
  // bounded so a stuck line cannot hang the run
  task automatic count_lvl(input int ch, input logic lvl, output int n);
    n = 0;
    while (pin[ch] === lvl && n < 9000) begin
      @(negedge sys_clk);
      n++;
    end
  endtask

  // first pass only syncs to a rising edge, partial pulses are dropped
  task automatic measure(input int ch, input int hi, input int lo);
    int h;
    int l;
    @(negedge sys_clk);
    count_lvl(ch, 1'b1, h);
    count_lvl(ch, 1'b0, l);
    count_lvl(ch, 1'b1, h);
    count_lvl(ch, 1'b0, l);
    chk(32'(h), 32'(hi));
    chk(32'(l), 32'(lo));
  endtask

  task automatic run_case(input int ch, input logic sel, input logic pol,
      input int a, input int b, input int dv, input int du, input int pr);
    int t;
    int hi;
    int lo;
    logic [3:0] bit_v;
    bit_v = 4'(1 << ch);
    @(posedge sys_clk);
    port_dir <= 4'($random(seed));
    wr(IDX_ENABLE, 8'h00);
    wr(IDX_PRESCL, 8'((b << 4) | a));
    wr(IDX_SCALE, 8'(dv));
    wr(IDX_SELPOL, {sel ? bit_v : 4'h0, pol ? bit_v : 4'h0});
    wr(14'(IDX_DUTY0 + ch), 8'(du));
    wr(14'(IDX_PERIOD0 + ch), 8'(pr));
    wr(IDX_ENABLE, {4'h0, bit_v});
    // cycles per channel count
    if (sel) t = 2 * (dv == 0 ? 256 : dv) * (1 << a);
    else t = (ch < 2) ? (1 << a) : (1 << b);
    hi = (pol ? du : pr - du) * t;
    lo = (pol ? pr - du : du) * t;
    measure(ch, hi, lo);
    chk({28'h0, port_oe}, {28'h0, port_dir | bit_v});
    chk({28'h0, pwm & ~bit_v}, 32'h0);
    wr(IDX_ENABLE, 8'h00);
    // gate closes only at the next channel clock edge
    repeat (t + 4) @(negedge sys_clk);
    chk({28'h0, pwm}, 32'h0);
    chk({28'h0, port_oe}, {28'h0, port_dir});
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ******************************************************************
  // main sequence and watchdog
  // ******************************************************************
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    seed = 31;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0;
    test_mode = 1'b0;
    port_dir = 4'h0;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rdc(IDX_SELPOL, 8'h00);
    rdc(IDX_ENABLE, 8'h00);
    rdc(IDX_SCALE, 8'h00);
    rdc(IDX_TEST, 8'h00);
    rdc(IDX_PERIOD0, 8'hff);
    chk({28'h0, port_oe | pwm}, 32'h0);
    d = $random(seed);
    wr(IDX_SELPOL, 8'(d));
    rdc(IDX_SELPOL, 8'(d));
    // refused: unmapped and unaligned
    apb(1'b1, 16'h41c0, 32'h5a, 34'h1_0000_0000);
    apb(1'b0, 16'h41c0, 32'h0, 34'h3_0000_0000);
    apb(1'b0, 16'h4189, 32'h0, 34'h3_0000_0000);
    // unaligned write into the duty block must leave it untouched
    apb(1'b1, 16'h4191, 32'h5a, 34'h1_0000_0000);
    rdc(IDX_DUTY0, 8'h00);
    // scaling counter readback in test mode
    test_mode <= 1'b1;
    wr(IDX_PRESCL, 8'h03);
    wr(IDX_TEST, 8'h01);
    wr(IDX_SCALE, 8'h40);
    repeat (300) @(posedge sys_clk);
    wr(IDX_SCALE, 8'h40);
    apb(1'b0, {IDX_SCALE, 2'b00}, 32'h0, 34'h0);
    chk({31'h0, rd < 32'h3}, 32'h1);
    test_mode <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rdc(IDX_SCALE, 8'h40);
    wr(IDX_TEST, 8'h00);
    // mid-run reset with a channel running: all back to reset values
    wr(IDX_ENABLE, 8'h01);
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rdc(IDX_ENABLE, 8'h00);
    rdc(IDX_PRESCL, 8'h00);
    chk({28'h0, port_oe | pwm}, 32'h0);
    for (int a = 0; a < 4; a++) begin
      d = 1 + (($random(seed) & 32'h7fffffff) % 3);
      run_case(0, 1'b0, 1'b1, a, 0, 1, d, 4);
    end
    for (int b = 0; b < 8; b++) begin
      d = 1 + (($random(seed) & 32'h7fffffff) % 3);
      run_case(2, 1'b0, 1'(b & 1), 0, b, 1, d, 4);
    end
    run_case(1, 1'b1, 1'b1, 0, 0, 3, 2, 4);
    run_case(3, 1'b1, 1'b0, 1, 0, 0, 1, 2);
    run_case(0, 1'b1, 1'b0, 0, 0, 1, 1, 4);
    wrap_up();
  end
endmodule
